// [hdl/ufrx_top.sv]
// USB function endpoint control, packet reception and mailbox status records
`timescale 1ns/1ps
// Operation
// - Each endpoint 0..6 has control register: max packet size and enable bit.
// - All control transfers with the host run on endpoint 0.
// - Received data goes to memory, then status record, then pointer advance.
// - Status record carries three-bit endpoint field; 001 means endpoint 0.
// - Status record carries 32-bit start address of receive buffer descriptor.
// - Detected errors show as separate bits in first status register.
// - Host bus reset gives default state and sets flag bit 17 at 0x18.
// - Writing 1 to bit 15 at 0x04 warm-resets; bit clears itself.
// - Seven-bit function address in mode register; only matching traffic accepted.
// - Receive record is two words; transmit record is one word.
// - Each committed packet or surviving transmit completion writes one record into mailbox bounded by start/bottom.
module ufrx_top
   import ufrx_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   // Receive side of the serial engine
   input wire logic BUS_RESET,
   input wire logic RX_TOKEN,
   input wire ufrx_token_type RX_TOKEN_INFO,
   input wire logic RX_BYTE_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic RX_EOP,
   input wire logic RX_CRC_OK,
   output logic RX_READY,
   output logic RX_ACK,
   // Transmit completions
   input wire logic TX_DONE,
   input wire logic [3:0] TX_EP,
   input wire logic [6:0] TX_LEN,
   // Memory write master
   output logic MEM_REQ,
   output ufrx_mem_type MEM_W,
   input wire logic MEM_ACK
);
   typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_REC0, ST_REC1, ST_TXREC} ufrx_state_type;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   ufrx_state_type state_q;
   logic soft_rst_q, bus_rst_d1_q, bus_rst_seen_q;
   logic [6:0] fa_q;
   logic [31:0] ep_q [NUM_EP];
   logic [31:0] rxmb_start_q, rxmb_bot_q, rxmb_rptr_q;
   logic [31:0] txmb_start_q, txmb_bot_q, txmb_rptr_q;
   logic rxmb_ld_q, txmb_ld_q;
   logic [31:0] cmd_ext_q, pool_addr_q, rx_desc_q;
   logic pool_q, take_q, rx_pend_q, rx_setup_q, ack_q, tx_pend_q;
   logic [3:0] rx_ep_q, tx_ep_q, err_q, widx_q;
   logic [6:0] rx_len_q, tx_len_q;
   ufrx_mem_type mem_q;
   logic [31:0] rd_d, rx_wptr, tx_wptr, g_word;
   logic [6:0] g_len;
   logic [3:0] g_idx, last_idx;
   logic g_long, tok_hit, tok_take, commit, rx_done, tx_done_now, tx_set;

   // ==========================================================
   // Helpers
   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = REG_WR && (REG_ADDR == ofs);
   endfunction : wr_hit

   function automatic logic ep_on(input logic [3:0] ep);
      ep_on = (ep < 4'(NUM_EP)) && ep_q[ep[2:0]][BIT_EP_EN];
   endfunction : ep_on

   function automatic logic [31:0] rec_word(input logic setup, input logic [3:0] ep,
      input logic [6:0] len);
      rec_word = RST_WORD;
      rec_word[REC_SETUP_BIT] = setup;
      rec_word[REC_EPN_LSB +: 3] = ep[2:0] + EPN_BASE;
      rec_word[6:0] = len;
   endfunction : rec_word

   // ==========================================================
   // Register writes
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_hit(OFS_CFG_CMD) && REG_WDATA[BIT_WARM_RST];
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         fa_q <= RST_FA;
      end else if (soft_rst_q || BUS_RESET) begin
         fa_q <= RST_FA;
      end else if (wr_hit(OFS_MODE)) begin
         fa_q <= REG_WDATA[6:0];
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < NUM_EP; i++) begin
            ep_q[i] <= RST_WORD;
         end
      end else begin
         for (int i = 0; i < NUM_EP; i++) begin
            if (soft_rst_q) begin
               ep_q[i] <= RST_WORD;
            end else if (wr_hit(OFS_EP_BASE + 8'(4 * i))) begin
               ep_q[i] <= {REG_WDATA[BIT_EP_EN], 24'h00_0000, REG_WDATA[6:0]};
            end
         end
      end
   end

   // Mailbox bounds; a write to a start register reloads its pointer
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         {rxmb_start_q, rxmb_bot_q, rxmb_rptr_q} <= {3{RST_WORD}};
         {txmb_start_q, txmb_bot_q, txmb_rptr_q} <= {3{RST_WORD}};
         {rxmb_ld_q, txmb_ld_q} <= 2'h0;
      end else begin
         rxmb_ld_q <= soft_rst_q || wr_hit(OFS_RXMB_START);
         txmb_ld_q <= soft_rst_q || wr_hit(OFS_TXMB_START);
         if (soft_rst_q) begin
            {rxmb_start_q, rxmb_bot_q, rxmb_rptr_q} <= {3{RST_WORD}};
            {txmb_start_q, txmb_bot_q, txmb_rptr_q} <= {3{RST_WORD}};
         end else begin
            if (wr_hit(OFS_RXMB_START)) rxmb_start_q <= REG_WDATA;
            if (wr_hit(OFS_RXMB_BOT)) rxmb_bot_q <= REG_WDATA;
            if (wr_hit(OFS_RXMB_RPTR)) rxmb_rptr_q <= REG_WDATA;
            if (wr_hit(OFS_TXMB_START)) txmb_start_q <= REG_WDATA;
            if (wr_hit(OFS_TXMB_BOT)) txmb_bot_q <= REG_WDATA;
            if (wr_hit(OFS_TXMB_RPTR)) txmb_rptr_q <= REG_WDATA;
         end
      end
   end

   // Receive pool: one descriptor at a time, add wins over consume
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cmd_ext_q <= RST_WORD;
         pool_addr_q <= RST_WORD;
         pool_q <= 1'b0;
      end else if (soft_rst_q) begin
         cmd_ext_q <= RST_WORD;
         pool_q <= 1'b0;
      end else begin
         if (wr_hit(OFS_CMD_EXT)) cmd_ext_q <= REG_WDATA;
         if (wr_hit(OFS_CMD) && REG_WDATA[BIT_ADD_POOL]) begin
            pool_q <= 1'b1;
            pool_addr_q <= cmd_ext_q;
         end else if (commit) begin
            pool_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Bus reset and error flags, hardware set wins over clear
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         bus_rst_d1_q <= 1'b0;
         bus_rst_seen_q <= 1'b0;
         err_q <= RST_ERR;
      end else begin
         bus_rst_d1_q <= BUS_RESET;
         if (BUS_RESET && !bus_rst_d1_q) begin
            bus_rst_seen_q <= 1'b1;
         end else if (wr_hit(OFS_STAT2) && REG_WDATA[BIT_BUS_RST_SEEN]) begin
            bus_rst_seen_q <= 1'b0;
         end
         for (int b = 0; b < 4; b++) begin
            if (wr_hit(OFS_STAT1) && REG_WDATA[b]) err_q[b] <= 1'b0;
         end
         if (tok_hit && !pool_q) err_q[ERR_NO_BUF] <= 1'b1;
         if (rx_done && !RX_CRC_OK) err_q[ERR_CRC] <= 1'b1;
         if (rx_done && RX_CRC_OK && g_long) err_q[ERR_TOO_LONG] <= 1'b1;
         if (tx_set && tx_pend_q && !tx_done_now) err_q[ERR_TX_LOST] <= 1'b1;
      end
   end

   // ==========================================================
   // Packet reception
   assign RX_READY = (state_q == ST_IDLE) && !rx_pend_q && !take_q && !BUS_RESET;
   assign tok_hit = RX_TOKEN && RX_READY && (RX_TOKEN_INFO.faddr == fa_q)
      && ep_on(RX_TOKEN_INFO.endp)
      && (!RX_TOKEN_INFO.setup || RX_TOKEN_INFO.endp == 4'h0);
   assign tok_take = tok_hit && pool_q;
   assign rx_done = take_q && RX_EOP;
   // Oversize means past the gather store or the endpoint's own limit
   assign commit = rx_done && RX_CRC_OK && !g_long
      && (g_len <= ep_q[rx_ep_q[2:0]][6:0]);

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         take_q <= 1'b0;
         rx_pend_q <= 1'b0;
         ack_q <= 1'b0;
         rx_ep_q <= 4'h0;
         rx_setup_q <= 1'b0;
         rx_len_q <= 7'h00;
         rx_desc_q <= RST_WORD;
      end else begin
         ack_q <= commit && !soft_rst_q;
         if (soft_rst_q || BUS_RESET || rx_done) begin
            take_q <= 1'b0;
         end else if (tok_take) begin
            take_q <= 1'b1;
            rx_ep_q <= RX_TOKEN_INFO.endp;
            rx_setup_q <= RX_TOKEN_INFO.setup;
         end
         if (soft_rst_q) begin
            rx_pend_q <= 1'b0;
         end else if (commit) begin
            rx_pend_q <= 1'b1;
            rx_len_q <= g_len;
            rx_desc_q <= pool_addr_q;
         end else if (state_q == ST_REC1 && MEM_ACK) begin
            rx_pend_q <= 1'b0;
         end
      end
   end

   assign RX_ACK = ack_q;
   assign g_idx = (state_q == ST_DATA) ? widx_q + 4'h1 : 4'h0;
   assign last_idx = 4'((rx_len_q - 7'h01) >> 2);

   ufrx_gather u_gather (
      .clk(CLOCK),
      .rst(RST),
      .clr(tok_take),
      .in_valid(take_q && RX_BYTE_VALID),
      .in_byte(RX_BYTE),
      .rd_idx(g_idx),
      .rd_word(g_word),
      .len(g_len),
      .too_long(g_long)
   );

   // ==========================================================
   // Transmit completions: one pending record, later one overwrites
   assign tx_set = TX_DONE && ep_on(TX_EP);
   assign tx_done_now = (state_q == ST_TXREC) && MEM_ACK;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         tx_pend_q <= 1'b0;
         tx_ep_q <= 4'h0;
         tx_len_q <= 7'h00;
      end else if (soft_rst_q) begin
         tx_pend_q <= 1'b0;
      end else if (tx_set) begin
         tx_pend_q <= 1'b1;
         tx_ep_q <= TX_EP;
         tx_len_q <= TX_LEN;
      end else if (tx_done_now) begin
         tx_pend_q <= 1'b0;
      end
   end

   // ==========================================================
   // Memory writer: data words, then record, then pointer advance
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
         widx_q <= 4'h0;
         mem_q <= {RST_WORD, RST_WORD};
      end else if (soft_rst_q) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               widx_q <= 4'h0;
               if (rx_pend_q && rx_len_q == 7'h00) begin
                  state_q <= ST_REC0;
                  mem_q <= {rx_wptr, rec_word(rx_setup_q, rx_ep_q, rx_len_q)};
               end else if (rx_pend_q) begin
                  state_q <= ST_DATA;
                  mem_q <= {rx_desc_q + DATA_OFS, g_word};
               end else if (tx_pend_q) begin
                  state_q <= ST_TXREC;
                  mem_q <= {tx_wptr, rec_word(1'b0, tx_ep_q, tx_len_q)};
               end
            end
            ST_DATA: begin
               if (MEM_ACK && widx_q == last_idx) begin
                  state_q <= ST_REC0;
                  mem_q <= {rx_wptr, rec_word(rx_setup_q, rx_ep_q, rx_len_q)};
               end else if (MEM_ACK) begin
                  widx_q <= widx_q + 4'h1;
                  mem_q <= {mem_q.addr + 32'h0000_0004, g_word};
               end
            end
            ST_REC0: begin
               if (MEM_ACK) begin
                  state_q <= ST_REC1;
                  mem_q <= {rx_wptr + 32'h0000_0004, rx_desc_q};
               end
            end
            ST_REC1: begin
               if (MEM_ACK) state_q <= ST_IDLE;
            end
            ST_TXREC: begin
               if (MEM_ACK) state_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign MEM_REQ = state_q != ST_IDLE;
   assign MEM_W = mem_q;

   ufrx_mbx #(.STEP(RX_REC_STEP)) u_rxmb (
      .clk(CLOCK),
      .rst(RST),
      .load(rxmb_ld_q),
      .adv(state_q == ST_REC1 && MEM_ACK && !soft_rst_q),
      .start(rxmb_start_q),
      .bottom(rxmb_bot_q),
      .wptr(rx_wptr)
   );

   ufrx_mbx #(.STEP(TX_REC_STEP)) u_txmb (
      .clk(CLOCK),
      .rst(RST),
      .load(txmb_ld_q),
      .adv(tx_done_now && !soft_rst_q),
      .start(txmb_start_q),
      .bottom(txmb_bot_q),
      .wptr(tx_wptr)
   );

   // ==========================================================
   // Register reads, answered one cycle after the strobe
   always_comb begin
      rd_d = RST_WORD;
      unique case (REG_ADDR)
         OFS_CFG_CMD: rd_d[BIT_WARM_RST] = soft_rst_q;
         OFS_MODE: rd_d[6:0] = fa_q;
         OFS_STAT1: rd_d[3:0] = err_q;
         OFS_STAT2: rd_d[BIT_BUS_RST_SEEN] = bus_rst_seen_q;
         OFS_RXMB_START: rd_d = rxmb_start_q;
         OFS_RXMB_BOT: rd_d = rxmb_bot_q;
         OFS_RXMB_WPTR: rd_d = rx_wptr;
         OFS_RXMB_RPTR: rd_d = rxmb_rptr_q;
         OFS_TXMB_START: rd_d = txmb_start_q;
         OFS_TXMB_BOT: rd_d = txmb_bot_q;
         OFS_TXMB_WPTR: rd_d = tx_wptr;
         OFS_TXMB_RPTR: rd_d = txmb_rptr_q;
         OFS_CMD: rd_d[BIT_ADD_POOL] = pool_q;
         OFS_CMD_EXT: rd_d = cmd_ext_q;
         default: begin
            for (int i = 0; i < NUM_EP; i++) begin
               if (REG_ADDR == OFS_EP_BASE + 8'(4 * i)) rd_d = ep_q[i];
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= RST_WORD;
      end else if (REG_RD) begin
         REG_RDATA <= rd_d;
      end
   end

   // ==========================================================
   // Checks
   a_ep_off_ignored: assert property (
      RX_TOKEN && RX_READY && !ep_on(RX_TOKEN_INFO.endp) |=> !take_q)
      else $error("token taken for disabled endpoint");
   a_addr_mismatch: assert property (
      RX_TOKEN && RX_READY && RX_TOKEN_INFO.faddr != fa_q |=> !take_q)
      else $error("token taken for foreign address");
   a_setup_only_ep0: assert property (
      RX_TOKEN && RX_READY && RX_TOKEN_INFO.setup && RX_TOKEN_INFO.endp != 4'h0 |=> !take_q)
      else $error("setup taken off endpoint 0");
   a_rx_ptr_after_rec: assert property (
      $changed(rx_wptr) |-> $past(rxmb_ld_q) || ($past(state_q) == ST_REC1 && $past(MEM_ACK)))
      else $error("receive pointer moved before record written");
   a_rec_ep_field: assert property (
      state_q == ST_REC0 |-> MEM_W.data[REC_EPN_LSB +: 3] == rx_ep_q[2:0] + EPN_BASE)
      else $error("record endpoint field wrong");
   a_rec_desc_word: assert property (
      state_q == ST_REC1 |-> MEM_W.data == rx_desc_q && MEM_W.addr == rx_wptr + 32'h0000_0004)
      else $error("record second word wrong");
   a_bus_rst_flag: assert property (
      $rose(BUS_RESET) |=> bus_rst_seen_q && fa_q == RST_FA)
      else $error("bus reset not flagged");
   a_warm_rst_clear: assert property (
      wr_hit(OFS_CFG_CMD) && REG_WDATA[BIT_WARM_RST] |=> soft_rst_q ##1 !soft_rst_q && !pool_q)
      else $error("warm reset bit did not act and clear");
   a_tx_one_word: assert property (
      $changed(tx_wptr) |-> $past(txmb_ld_q) || ($past(state_q) == ST_TXREC && $past(MEM_ACK)))
      else $error("transmit pointer moved without one-word record");
endmodule : ufrx_top

// [hdl/ufrx_pkg.sv]
// Shared constants and types for the USB function receive and status block
package ufrx_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_CFG_CMD = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_STAT1 = 8'h14;
   localparam logic [7:0] OFS_STAT2 = 8'h18;
   localparam logic [7:0] OFS_RXMB_START = 8'h20;
   localparam logic [7:0] OFS_RXMB_BOT = 8'h24;
   localparam logic [7:0] OFS_RXMB_WPTR = 8'h28;
   localparam logic [7:0] OFS_RXMB_RPTR = 8'h2C;
   localparam logic [7:0] OFS_TXMB_START = 8'h30;
   localparam logic [7:0] OFS_TXMB_BOT = 8'h34;
   localparam logic [7:0] OFS_TXMB_WPTR = 8'h38;
   localparam logic [7:0] OFS_TXMB_RPTR = 8'h3C;
   localparam logic [7:0] OFS_CMD = 8'h40;
   localparam logic [7:0] OFS_CMD_EXT = 8'h44;
   localparam logic [7:0] OFS_EP_BASE = 8'h80;
   // ==========================================================
   // Field positions
   localparam int BIT_WARM_RST = 15;
   localparam int BIT_BUS_RST_SEEN = 17;
   localparam int BIT_EP_EN = 31;
   localparam int BIT_ADD_POOL = 0;
   localparam int ERR_NO_BUF = 0;
   localparam int ERR_CRC = 1;
   localparam int ERR_TOO_LONG = 2;
   localparam int ERR_TX_LOST = 3;
   localparam int REC_SETUP_BIT = 31;
   localparam int REC_EPN_LSB = 16;
   // ==========================================================
   // Sizes, codes and reset values
   localparam int NUM_EP = 7;
   localparam int MAX_PKT_BYTES = 64;
   localparam int PKT_WORDS = 16;
   localparam logic [2:0] EPN_BASE = 3'h1;
   localparam logic [31:0] DATA_OFS = 32'h0000_0008;
   localparam logic [31:0] RX_REC_STEP = 32'h0000_0008;
   localparam logic [31:0] TX_REC_STEP = 32'h0000_0004;
   localparam logic [6:0] RST_FA = 7'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [3:0] RST_ERR = 4'h0;

   typedef struct packed {
      logic [6:0] faddr;
      logic [3:0] endp;
      logic setup;
   } ufrx_token_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } ufrx_mem_type;

   // Next record slot; wraps when a whole record no longer fits
   function automatic logic [31:0] ufrx_next_ptr(input logic [31:0] ptr,
      input logic [31:0] step, input logic [31:0] start, input logic [31:0] bottom);
      logic [31:0] nxt;
      nxt = ptr + step;
      if (nxt + step - 32'h0000_0004 > bottom) begin
         ufrx_next_ptr = start;
      end else begin
         ufrx_next_ptr = nxt;
      end
   endfunction : ufrx_next_ptr
endpackage : ufrx_pkg

// [hdl/ufrx_mbx.sv]
// Mailbox write pointer with wrap between start and bottom
`timescale 1ns/1ps
module ufrx_mbx
   import ufrx_pkg::*;
#(
   parameter logic [31:0] STEP = RX_REC_STEP
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic load,
   input wire logic adv,
   input wire logic [31:0] start,
   input wire logic [31:0] bottom,
   // Pointer
   output logic [31:0] wptr
);
   logic [31:0] wptr_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wptr_q <= RST_WORD;
      end else if (load) begin
         wptr_q <= start;
      end else if (adv) begin
         wptr_q <= ufrx_next_ptr(wptr_q, STEP, start, bottom);
      end
   end

   assign wptr = wptr_q;

   a_mbx_wrap_start: assert property (@(posedge clk) disable iff (rst)
      adv && !load && (wptr_q + STEP + STEP - 32'h0000_0004 > bottom)
      |=> wptr_q == $past(start))
      else $error("mailbox pointer did not wrap to start");
endmodule : ufrx_mbx

// [hdl/ufrx_gather.sv]
// Packet byte collector: packs bytes into words, little-endian
`timescale 1ns/1ps
module ufrx_gather
   import ufrx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Byte input
   input wire logic clr,
   input wire logic in_valid,
   input wire logic [7:0] in_byte,
   // Word read side
   input wire logic [3:0] rd_idx,
   output logic [31:0] rd_word,
   output logic [6:0] len,
   output logic too_long
);
   logic [31:0] mem_q [PKT_WORDS];
   logic [6:0] len_q;
   logic too_long_q;
   logic room;

   assign room = len_q < 7'(MAX_PKT_BYTES);

   // No reset on the store: bytes past len are read only as padding in the last data word
   always_ff @(posedge clk) begin
      if (in_valid && !clr && room) begin
         mem_q[len_q[5:2]][{len_q[1:0], 3'h0} +: 8] <= in_byte;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         len_q <= 7'h00;
         too_long_q <= 1'b0;
      end else if (clr) begin
         len_q <= 7'h00;
         too_long_q <= 1'b0;
      end else if (in_valid) begin
         if (room) begin
            len_q <= len_q + 7'h01;
         end else begin
            too_long_q <= 1'b1;
         end
      end
   end

   assign rd_word = mem_q[rd_idx];
   assign len = len_q;
   assign too_long = too_long_q;
endmodule : ufrx_gather

// [test/ufrx_host.sv]
// Host side model: sends tokens, data bytes and end of packet
`timescale 1ns/1ps
module ufrx_host
   import ufrx_pkg::*;
(
   // Clock
   input wire logic clk,
   // Receive link
   output logic tok,
   output ufrx_token_type info,
   output logic vld,
   output logic [7:0] dat,
   output logic eop,
   output logic crc_ok
);
   initial begin
      {tok, vld, eop, crc_ok} = 4'h0;
      info = 12'h000;
      dat = 8'h00;
   end
   // ==========================================================
   // Packet; idle fields invert so stale values never match
   task automatic send(input ufrx_token_type t, input logic [7:0] b[$]);
      @(posedge clk) #1;
      tok = 1'b1;
      info = t;
      @(posedge clk) #1;
      tok = 1'b0;
      info = ~t;
      foreach (b[i]) begin
         vld = 1'b1;
         dat = b[i];
         @(posedge clk) #1;
      end
      vld = 1'b0;
      dat = ~dat;
      eop = 1'b1;
      crc_ok = 1'b1;
      @(posedge clk) #1;
      eop = 1'b0;
      crc_ok = 1'b0;
   endtask : send
endmodule : ufrx_host

// [test/ufrx_top_bench.sv]
// Self-checking bench for the USB function receive block
`timescale 1ns/1ps
module ufrx_top_bench
   import ufrx_pkg::*;
();
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [7:0] REG_ADDR = 8'h00;
   logic [31:0] REG_WDATA = 32'h0000_0000;
   logic BUS_RESET = 1'b0;
   logic MEM_ACK = 1'b0;
   logic TX_DONE = 1'b0;
   logic [3:0] TX_EP = 4'h0;
   logic [6:0] TX_LEN = 7'h00;
   logic [31:0] REG_RDATA;
   logic RX_READY, RX_ACK, MEM_REQ, tok, vld, eop, crc;
   logic [7:0] dat;
   ufrx_token_type info;
   ufrx_mem_type MEM_W;
   ufrx_mem_type exp_q[$];
   logic [7:0] lfsr_q = 8'h14;
   logic [31:0] desc, wp;
   int err_total = 0;
   int checked = 0;
   always #2.5 CLOCK = ~CLOCK;
   ufrx_top ufrx_top_i (.CLOCK(CLOCK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .BUS_RESET(BUS_RESET), .RX_TOKEN(tok), .RX_TOKEN_INFO(info), .RX_BYTE_VALID(vld),
      .RX_BYTE(dat), .RX_EOP(eop), .RX_CRC_OK(crc), .RX_READY(RX_READY), .RX_ACK(RX_ACK),
      .TX_DONE(TX_DONE), .TX_EP(TX_EP), .TX_LEN(TX_LEN), .MEM_REQ(MEM_REQ), .MEM_W(MEM_W),
      .MEM_ACK(MEM_ACK));
   ufrx_host ufrx_host_i (.clk(CLOCK), .tok(tok), .info(info), .vld(vld), .dat(dat),
      .eop(eop), .crc_ok(crc));
   // ==========================================================
   // Helpers
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      return lfsr_q;
   endfunction : rnd
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK) #1;
      {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
      @(posedge CLOCK) #1;
      REG_WR = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge CLOCK) #1;
      {REG_RD, REG_ADDR} = {1'b1, a};
      @(posedge CLOCK) #1;
      REG_RD = 1'b0;
      chk(REG_RDATA & m, e);
   endtask : rd
   task automatic pool(input logic [31:0] d);
      wr(OFS_CMD_EXT, d);
      wr(OFS_CMD, 32'h0000_0001);
      desc = d;
   endtask : pool
   // Model: data words, then record pair, then pointer step with wrap
   task automatic pkt(input ufrx_token_type t, input int n, input logic ok);
      logic [7:0] b[$];
      logic seen;
      for (int k = 0; k < n; k++) b.push_back(rnd());
      if (ok) begin
         for (int k = 0; k < n; k += 4) exp_q.push_back(ufrx_mem_type'{desc + 32'h8 + k,
            {b[k+3], b[k+2], b[k+1], b[k]}});
         exp_q.push_back(ufrx_mem_type'{wp, {t.setup, 12'h000, t.endp[2:0] + 3'h1,
            9'h000, n[6:0]}});
         exp_q.push_back(ufrx_mem_type'{wp + 32'h4, desc});
         wp = (wp + 32'hC > 32'h0000_100F) ? 32'h0000_1000 : wp + 32'h8;
      end
      seen = 1'b0;
      ufrx_host_i.send(t, b);
      // Acknowledge pulse is already up when the send returns
      repeat (12) begin
         seen = seen | RX_ACK;
         @(posedge CLOCK) #1;
      end
      chk(seen, ok);
      repeat (200) if (exp_q.size() != 0) @(posedge CLOCK);
      chk(exp_q.size(), 0);
      rd(OFS_RXMB_WPTR, 32'hFFFF_FFFF, wp);
      wr(OFS_RXMB_RPTR, wp);
      $display("test packet ep %0d len %0d finished", t.endp, n);
   endtask : pkt
   // Memory slave with random stalls; every write is compared with the model
   // Word is compared when acknowledged; it stands until the edge that takes it
   always @(posedge CLOCK) begin
      #1;
      if (MEM_REQ === 1'b1 && MEM_ACK === 1'b0 && rnd() > 8'h50) begin
         if (exp_q.size() == 0) chk(64'h1, 64'h0);
         else chk(MEM_W, exp_q.pop_front());
         MEM_ACK = 1'b1;
      end else begin
         MEM_ACK = 1'b0;
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
   // ==========================================================
   // Sequence
   initial begin
      repeat (2) @(posedge CLOCK);
      #1 RST = 1'b0;
      wr(OFS_RXMB_START, 32'h0000_1000);
      wr(OFS_RXMB_BOT, 32'h0000_100F);
      wr(OFS_EP_BASE, 32'h8000_0040);
      wp = 32'h0000_1000;
      pool(32'h0000_2000);
      pkt(ufrx_token_type'{7'h00, 4'h0, 1'b1}, 8, 1'b1);
      pool(32'h0000_3000);
      pkt(ufrx_token_type'{7'h00, 4'h0, 1'b0}, 0, 1'b1);
      pkt(ufrx_token_type'{7'h00, 4'h0, 1'b0}, 4, 1'b0);
      rd(OFS_STAT1, 32'h0000_0001, 32'h0000_0001);
      pool(32'h0000_4000);
      pkt(ufrx_token_type'{7'h00, 4'h3, 1'b0}, 4, 1'b0);
      wr(OFS_EP_BASE + 8'h0C, 32'h8000_0004);
      pkt(ufrx_token_type'{7'h00, 4'h3, 1'b0}, 4, 1'b1);
      wr(OFS_MODE, 32'h0000_0005);
      pool(32'h0000_5000);
      pkt(ufrx_token_type'{7'h00, 4'h0, 1'b0}, 4, 1'b0);
      pkt(ufrx_token_type'{7'h05, 4'h0, 1'b0}, 4, 1'b1);
      wr(OFS_TXMB_START, 32'h0000_1100);
      wr(OFS_TXMB_BOT, 32'h0000_1107);
      wr(OFS_EP_BASE + 8'h14, 32'h8000_0040);
      exp_q.push_back(ufrx_mem_type'{32'h0000_1100, 32'h0006_0004});
      @(posedge CLOCK) #1 {TX_DONE, TX_EP, TX_LEN} = {1'b1, 4'h5, 7'h04};
      @(posedge CLOCK) #1 TX_DONE = 1'b0;
      repeat (50) @(posedge CLOCK);
      chk(exp_q.size(), 0);
      rd(OFS_TXMB_WPTR, 32'hFFFF_FFFF, 32'h0000_1104);
      $display("test transmit record finished");
      @(posedge CLOCK) #1 BUS_RESET = 1'b1;
      repeat (3) @(posedge CLOCK);
      chk(RX_READY, 1'b0);
      #1 BUS_RESET = 1'b0;
      rd(OFS_STAT2, 32'h0002_0000, 32'h0002_0000);
      rd(OFS_MODE, 32'h0000_007F, 32'h0000_0000);
      $display("test bus reset finished");
      wr(OFS_CFG_CMD, 32'h0000_8000);
      repeat (4) @(posedge CLOCK);
      rd(OFS_CFG_CMD, 32'h0000_8000, 32'h0000_0000);
      rd(OFS_EP_BASE, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(OFS_RXMB_WPTR, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(OFS_RXMB_START, 32'h0000_1000);
      rd(OFS_RXMB_WPTR, 32'hFFFF_FFFF, 32'h0000_1000);
      $display("test warm reset finished");
      end_sim();
   end
endmodule : ufrx_top_bench
